// ==== hw/flash_rd_map.vh ====
`ifndef FLASH_RD_MAP_VH
`define FLASH_RD_MAP_VH
// opcodes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0B
`define OP_DUAL_OUT      8'h3B
`define OP_DUAL_IO       8'hBB
`define OP_ENTER_WIDE    8'hB7
`define OP_EXIT_WIDE     8'hE9
`define OP_PARAM_TABLE   8'h5A
`define OP_SIGNATURE     8'hAB
`define OP_MAKER_DEV_ID  8'h90
// configuration register field positions
`define CFG_WIDE_BIT     5
`define CFG_DC_LO_BIT    6
`define CFG_DC_HI_BIT    7
`define CFG_RESET        8'h00
// dummy clock counts
`define DUMMY_FAST       6'd8
`define DUMMY_DUAL_IO_LO 6'd4
`define DUMMY_DUAL_IO_HI 6'd8
// address widths in bits
`define ADDR_NARROW      6'd24
`define ADDR_WIDE        6'd32
`define ADDR_LEGACY      6'd24
`endif

// ==== hw/rd_fifo.v ====
// small synchronous fifo with valid/ready on both sides
module rd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             clr,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire            empty = (wr_q == rd_q);
  wire            push  = in_valid && !full;
  wire            pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (clr) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule // rd_fifo

// ==== hw/flash_read_slave.v ====
// Functional notes
// - out of reset, reads take three address bytes
// - enter-wide command switches address phases to four bytes
// - enter-wide command sets configuration bit 5
// - wide mode ends only by exit command or reset
// - in wide mode all commands work; only address width grows
// - parameter-table, signature and id reads keep legacy address width
// - exit-wide command clears bit 5, back to three bytes
// - address sampled on rising clock, data driven on falling clock
// - address increments per byte and wraps to zero at top
// - plain read is opcode, address, data; select high ends it
// - reads rejected while an internal write cycle is busy
// - fast read inserts 8 dummy clocks by default
// - dual io dummy count follows configuration bit 6 only; bit 7 is not used
// - three-byte default; high memory by wide mode or extended bit
// - dual-output: address and dummy on line 0, data on lines 1,0
// - dual io: address, dummy and data two bits per clock
// - dual io uses 4 dummy clocks by default on two lines
// - quad lanes unused by these commands; quad enable is outside
`include "flash_rd_map.vh"
module flash_read_slave #(
  parameter MEM_AW = 25
) (
  input  wire              CORE_CLK,
  input  wire              RSTN,
  input  wire              CS_N,
  input  wire              SCLK,
  input  wire              IO_LINE0_IN,
  output reg               IO_LINE0_OUT,
  output reg               IO_LINE0_OE,
  input  wire              IO_LINE1_IN,
  output reg               IO_LINE1_OUT,
  output reg               IO_LINE1_OE,
  output wire              IO_LINE2_OE,
  output wire              IO_LINE3_OE,
  input  wire              BUSY,
  input  wire              DUMMY_COUNT_SEL_LO,
  input  wire              DUMMY_COUNT_SEL_HI,
  input  wire              EXTENDED_ADDRESS_REG_BIT,
  output wire              WIDE_ADDRESS_FLAG,
  output wire [7:0]        CFG_VIEW,
  output reg  [MEM_AW-1:0] MEM_ADDR,
  output reg               MEM_REQ,
  input  wire              MEM_READY,
  input  wire [7:0]        MEM_DATA,
  input  wire              MEM_VALID,
  output wire              FIFO_READY,
  output reg               REJECTED
);
  // frame phases, one per part of a command
  localparam ST_IDLE  = 3'd0;
  localparam ST_CMD   = 3'd1;
  localparam ST_ADDR  = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_DATA  = 3'd4;
  localparam ST_SKIP  = 3'd5;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] cs_s_q;
  reg [1:0] clk_s_q;
  reg [1:0] d0_s_q;
  reg [1:0] d1_s_q;
  reg       clk_prev_q;

  // two flops on every pin
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_s_q     <= 2'h3;
      clk_s_q    <= 2'h0;
      d0_s_q     <= 2'h0;
      d1_s_q     <= 2'h0;
      clk_prev_q <= 1'b0;
    end else begin
      cs_s_q     <= {cs_s_q[0], CS_N};
      clk_s_q    <= {clk_s_q[0], SCLK};
      d0_s_q     <= {d0_s_q[0], IO_LINE0_IN};
      d1_s_q     <= {d1_s_q[0], IO_LINE1_IN};
      clk_prev_q <= clk_s_q[1];
    end
  end

  // edges count only while selected
  wire cs_act = !cs_s_q[1];
  wire rise   = cs_act && clk_s_q[1] && !clk_prev_q;
  wire fall   = cs_act && !clk_s_q[1] && clk_prev_q;
  wire d0     = d0_s_q[1];
  wire d1     = d1_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // transfer state
  // phase, configuration and input shift register
  reg [2:0]        st_q;
  reg [7:0]        cfg_q;
  reg [31:0]       sh_q;
  // bit counter and the lengths it is compared with
  reg [5:0]        cnt_q;
  reg [5:0]        alen_q;
  reg [5:0]        dmy_q;
  // lane use of the command in flight
  reg              two_addr_q;
  reg              two_data_q;
  reg              two_dmy_q;
  // output byte, bit position within it, byte held
  reg [7:0]        obyte_q;
  reg [3:0]        obit_q;
  reg              have_q;
  // fetch state and frame bookkeeping
  reg              pend_q;
  reg [MEM_AW-1:0] next_q;
  reg              opened_q;
  reg [1:0]        mode_q; // bit0 enter, bit1 exit, armed after opcode only

  // decoded mode and dummy choices
  wire [7:0] cmd_now = {sh_q[6:0], d0};
  wire       wide    = cfg_q[`CFG_WIDE_BIT];
  wire [1:0] dc_sel  = {DUMMY_COUNT_SEL_HI, DUMMY_COUNT_SEL_LO};
  wire [5:0] alen_rd = wide ? `ADDR_WIDE : `ADDR_NARROW;
  wire [5:0] dio_dmy = dc_sel[0] ? `DUMMY_DUAL_IO_HI : `DUMMY_DUAL_IO_LO;

  // fifo between memory fetch and pin shifter
  wire [7:0] f_data;
  wire       f_valid;
  wire       last_bit = (obit_q == (two_data_q ? 4'd3 : 4'd7));
  // pop only when the shifter loads: empty shifter, or last bit of a byte leaving
  wire       f_take = f_valid && cs_act && (st_q == ST_DATA) &&
                      (!have_q || (fall && last_bit));
  wire       f_clr  = !cs_act;

  rd_fifo #(
    .WIDTH (8),
    .DEPTH (32),
    .AW    (5)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rstn      (RSTN),
    .clr       (f_clr),
    .in_data   (MEM_DATA),
    .in_valid  (MEM_VALID),
    .in_ready  (FIFO_READY),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_take)
  );

  // status views and the unused quad lanes
  assign WIDE_ADDRESS_FLAG = wide;
  assign CFG_VIEW          = {DUMMY_COUNT_SEL_HI, DUMMY_COUNT_SEL_LO, cfg_q[5:0]};
  assign IO_LINE2_OE       = 1'b0;
  assign IO_LINE3_OE       = 1'b0;

  // command decode, address, dummy, data phases
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q       <= ST_IDLE;
      cfg_q      <= `CFG_RESET;
      sh_q       <= 32'h0000_0000;
      cnt_q      <= 6'd0;
      alen_q     <= 6'd0;
      dmy_q      <= 6'd0;
      two_addr_q <= 1'b0;
      two_data_q <= 1'b0;
      two_dmy_q  <= 1'b0;
      REJECTED   <= 1'b0;
      opened_q   <= 1'b0;
      mode_q     <= 2'b00;
    end else if (!cs_act) begin
      // select high ends any phase
      if (opened_q && mode_q != 2'b00) begin
        // mode commands act at select rise after opcode only
        if (mode_q[0]) cfg_q[`CFG_WIDE_BIT] <= 1'b1;
        if (mode_q[1]) cfg_q[`CFG_WIDE_BIT] <= 1'b0;
      end
      st_q     <= ST_CMD;
      cnt_q    <= 6'd0;
      opened_q <= 1'b0;
      mode_q   <= 2'b00;
    end else if (rise) begin
      opened_q <= 1'b1;
      mode_q   <= 2'b00; // a bit after the opcode cancels a mode command
      case (st_q)
        ST_CMD: begin
          sh_q  <= {sh_q[30:0], d0};
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'd7) begin
            two_addr_q <= 1'b0;
            two_data_q <= 1'b0;
            two_dmy_q  <= 1'b0;
            alen_q     <= alen_rd;
            dmy_q      <= 6'd0;
            // opcode complete: pick lanes, address length, dummies
            case (cmd_now)
              `OP_READ: st_q <= ST_ADDR;
              `OP_FAST_READ: begin
                st_q  <= ST_ADDR;
                dmy_q <= `DUMMY_FAST;
              end
              `OP_DUAL_OUT: begin
                st_q       <= ST_ADDR;
                dmy_q      <= `DUMMY_FAST;
                two_data_q <= 1'b1;
              end
              `OP_DUAL_IO: begin
                st_q       <= ST_ADDR;
                dmy_q      <= dio_dmy;
                two_addr_q <= 1'b1;
                two_data_q <= 1'b1;
                two_dmy_q  <= 1'b1;
              end
              `OP_PARAM_TABLE, `OP_SIGNATURE, `OP_MAKER_DEV_ID: begin
                alen_q <= `ADDR_LEGACY;
                st_q   <= ST_SKIP;
              end
              // wide-address mode commands: opcode only, applied at select rise
              `OP_ENTER_WIDE: begin
                st_q   <= ST_SKIP;
                mode_q <= 2'b01;
              end
              `OP_EXIT_WIDE: begin
                st_q   <= ST_SKIP;
                mode_q <= 2'b10;
              end
              // unknown opcodes sit out the rest of the frame
              default: st_q <= ST_SKIP;
            endcase
            // busy internal cycle refuses reads and is left undisturbed
            if (BUSY && (cmd_now == `OP_READ || cmd_now == `OP_FAST_READ ||
                         cmd_now == `OP_DUAL_OUT || cmd_now == `OP_DUAL_IO)) begin
              st_q     <= ST_SKIP;
              REJECTED <= 1'b1;
            end
            cnt_q <= 6'd0;
          end
        end
        ST_ADDR: begin
          if (two_addr_q) begin
            sh_q  <= {sh_q[29:0], d1, d0};
            cnt_q <= cnt_q + 6'd2;
          end else begin
            sh_q  <= {sh_q[30:0], d0};
            cnt_q <= cnt_q + 6'd1;
          end
          // last address bit moves on to dummy or data
          if (cnt_q + (two_addr_q ? 6'd2 : 6'd1) == alen_q) begin
            cnt_q <= 6'd0;
            st_q  <= (dmy_q == 6'd0) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // dummy bits carry no meaning; dual io clocks two lanes of them
          if (two_dmy_q) sh_q <= {sh_q[29:0], d1, d0};
          else sh_q <= {sh_q[30:0], d0};
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q + 6'd1 == dmy_q) st_q <= ST_DATA;
        end
        // data and skip phases last until select rises
        ST_DATA: st_q <= ST_DATA;
        ST_SKIP: st_q <= ST_SKIP;
        default: st_q <= ST_IDLE;
      endcase
    end else begin
      REJECTED <= 1'b0;
    end
  end

  // captured start address, narrowed with extended bit when not wide
  wire [31:0] a_full = two_addr_q ? {sh_q[29:0], d1, d0} : {sh_q[30:0], d0};
  wire [31:0] a_eff  = (alen_q == `ADDR_WIDE) ? a_full :
                       {7'h00, EXTENDED_ADDRESS_REG_BIT, a_full[23:0]};
  wire addr_done = rise && st_q == ST_ADDR &&
                   (cnt_q + (two_addr_q ? 6'd2 : 6'd1) == alen_q);

  ////////////////////////////////////////////////////////////////////////////
  // memory prefetch into fifo, address wraps at top
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_ADDR <= {MEM_AW{1'b0}};
      MEM_REQ  <= 1'b0;
      next_q   <= {MEM_AW{1'b0}};
      pend_q   <= 1'b0;
    end else if (!cs_act) begin
      // an offered request is held until taken, even past the frame
      if (MEM_READY) MEM_REQ <= 1'b0;
      pend_q <= 1'b0;
    end else if (addr_done) begin
      // first fetch goes out with the address so data beats the first fall
      MEM_REQ  <= 1'b1;
      MEM_ADDR <= a_eff[MEM_AW-1:0];
      next_q   <= a_eff[MEM_AW-1:0];
      pend_q   <= 1'b1;
    end else if (pend_q) begin
      if (MEM_REQ && MEM_READY) begin
        MEM_REQ <= 1'b0;
        next_q  <= next_q + 1'b1;
      end else if (!MEM_REQ && FIFO_READY && !MEM_VALID) begin
        MEM_REQ  <= 1'b1;
        MEM_ADDR <= next_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shifter, drives on falling clock
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      obyte_q      <= 8'h00;
      obit_q       <= 4'd0;
      have_q       <= 1'b0;
      IO_LINE0_OUT <= 1'b0;
      IO_LINE0_OE  <= 1'b0;
      IO_LINE1_OUT <= 1'b0;
      IO_LINE1_OE  <= 1'b0;
    end else if (!cs_act || st_q != ST_DATA) begin
      obit_q      <= 4'd0;
      have_q      <= 1'b0;
      IO_LINE0_OE <= 1'b0;
      IO_LINE1_OE <= 1'b0;
    end else begin
      // first byte of the data phase
      if (f_take && !have_q) begin
        obyte_q <= f_data;
        have_q  <= 1'b1;
      end
      // one bit per fall on line 1, or a pair on lines 1 and 0
      if (fall && have_q) begin
        if (two_data_q) begin
          IO_LINE1_OUT <= obyte_q[7];
          IO_LINE0_OUT <= obyte_q[6];
          IO_LINE0_OE  <= 1'b1;
          IO_LINE1_OE  <= 1'b1;
          obit_q       <= (obit_q == 4'd3) ? 4'd0 : obit_q + 4'd1;
          obyte_q      <= (obit_q == 4'd3) ? f_data : {obyte_q[5:0], 2'b00};
          have_q       <= (obit_q != 4'd3) || f_valid;
        end else begin
          IO_LINE1_OUT <= obyte_q[7];
          IO_LINE1_OE  <= 1'b1;
          obit_q       <= (obit_q == 4'd7) ? 4'd0 : obit_q + 4'd1;
          obyte_q      <= (obit_q == 4'd7) ? f_data : {obyte_q[6:0], 1'b0};
          have_q       <= (obit_q != 4'd7) || f_valid;
        end
      end
    end
  end
endmodule // flash_read_slave

// ==== testbench/flash_read_checker_sva.sv ====
module flash_read_checker #(
  parameter MEM_AW = 25
) (
  input wire              CORE_CLK,
  input wire              RSTN,
  input wire              CS_N,
  input wire              DUMMY_COUNT_SEL_LO,
  input wire              DUMMY_COUNT_SEL_HI,
  input wire              IO_LINE0_OE,
  input wire              IO_LINE1_OE,
  input wire              IO_LINE2_OE,
  input wire              IO_LINE3_OE,
  input wire              WIDE_ADDRESS_FLAG,
  input wire [7:0]        CFG_VIEW,
  input wire [MEM_AW-1:0] MEM_ADDR,
  input wire              MEM_REQ,
  input wire              MEM_READY,
  input wire              REJECTED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  property p_hi_lines; !IO_LINE2_OE && !IO_LINE3_OE; endproperty
  a_hi_lines: assert property (p_hi_lines) else $error("upper lines driven");
  property p_cfg_wide; CFG_VIEW[5] == WIDE_ADDRESS_FLAG; endproperty
  a_cfg_wide: assert property (p_cfg_wide) else $error("wide bit mismatch");
  property p_cfg_dc; $stable({DUMMY_COUNT_SEL_HI, DUMMY_COUNT_SEL_LO}) [*3] |->
    CFG_VIEW[7:6] == {DUMMY_COUNT_SEL_HI, DUMMY_COUNT_SEL_LO}; endproperty
  a_cfg_dc: assert property (p_cfg_dc) else $error("dummy select view wrong");
  property p_flag_cs; $changed(WIDE_ADDRESS_FLAG) |-> CS_N; endproperty
  a_flag_cs: assert property (p_flag_cs) else $error("mode changed in frame");
  property p_rej; $rose(REJECTED) |-> (!MEM_REQ && !IO_LINE1_OE) [*8]; endproperty
  a_rej: assert property (p_rej) else $error("refused read went on");
  property p_req_hold; MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR); endproperty
  a_req_hold: assert property (p_req_hold) else $error("fetch request dropped");
  property p_oe_idle; CS_N [*4] |-> !IO_LINE0_OE && !IO_LINE1_OE; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drives while deselected");
  property p_dual; IO_LINE0_OE |-> IO_LINE1_OE; endproperty
  a_dual: assert property (p_dual) else $error("line 0 driven alone");
endmodule // flash_read_checker

bind flash_read_slave flash_read_checker #(.MEM_AW(MEM_AW)) chk (.*);

// ==== testbench/flash_host.sv ====
module flash_host (
  input  wire logic clk,
  input  wire logic q0,
  input  wire logic oe0,
  input  wire logic q1,
  input  wire logic oe1,
  output logic      cs_n,
  output logic      sclk,
  output logic      w0,
  output logic      w1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       h0 = 1'b0, h1 = 1'b0, e0 = 1'b0, e1 = 1'b0, tg = 1'b0;
  logic [7:0] rb [0:3];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // released lines show a toggling pattern
  always @(posedge clk) tg <= ~tg;
  assign w0 = oe0 ? q0 : (e0 ? h0 : tg);
  assign w1 = oe1 ? q1 : (e1 ? h1 : ~tg);
  ////////////////////////////////////////////////////////////////////////////////
  // one serial clock, data changes while low, device samples on the rise
  task automatic sck();
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    sclk <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // opcode, address on al lanes, nd dummy clocks, nb bytes on dl lanes
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int na,
                       input int al, input int nd, input int nb, input int dl);
    logic [7:0] b;
    cs_n <= 1'b0;
    e0 <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      h0 <= op[i];
      sck();
    end
    e1 <= (al == 2);
    for (int i = na - 1; i >= 0; i -= al) begin
      h1 <= ad[i];
      h0 <= ad[i-al+1];
      sck();
    end
    e0 <= 1'b0;
    e1 <= 1'b0;
    repeat (nd) sck();
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8; j += dl) begin
        sck();
        b = (dl == 2) ? {b[5:0], w1, w0} : {b[6:0], w1};
      end
      rb[k] = b;
    end
    sclk <= 1'b0;
    cs_n <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
endmodule // flash_host

// ==== testbench/serial_flash_read_addr_mode_tb.sv ====
`include "flash_rd_map.vh"
module serial_flash_read_addr_mode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK = 1'b0, RSTN = 1'b0, BUSY = 1'b0, EXTENDED_ADDRESS_REG_BIT = 1'b0;
  logic        DUMMY_COUNT_SEL_LO = 1'b0, DUMMY_COUNT_SEL_HI = 1'b0;
  logic        MEM_READY = 1'b0, MEM_VALID = 1'b0;
  logic [7:0]  MEM_DATA = 8'h00;
  wire         CS_N, SCLK, IO_LINE0_IN, IO_LINE1_IN, IO_LINE0_OUT, IO_LINE1_OUT;
  wire         IO_LINE0_OE, IO_LINE1_OE, IO_LINE2_OE, IO_LINE3_OE;
  wire         WIDE_ADDRESS_FLAG, MEM_REQ, FIFO_READY, REJECTED;
  wire [7:0]   CFG_VIEW;
  wire [24:0]  MEM_ADDR;
  int          mismatches = 0, check_count = 0, rej_n = 0;
  flash_read_slave DUT (.*);
  flash_host host (.clk(CORE_CLK), .q0(IO_LINE0_OUT), .oe0(IO_LINE0_OE), .q1(IO_LINE1_OUT),
    .oe1(IO_LINE1_OE), .cs_n(CS_N), .sclk(SCLK), .w0(IO_LINE0_IN), .w1(IO_LINE1_IN));
  always #2 CORE_CLK = ~CORE_CLK;
  function automatic logic [7:0] pat(input logic [24:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {a[24], 7'h00};
  endfunction
  // memory: every request stalls one cycle, data follows acceptance
  always @(posedge CORE_CLK) begin
    MEM_READY <= MEM_REQ & ~MEM_READY;
    MEM_VALID <= MEM_REQ & MEM_READY;
    MEM_DATA <= pat(MEM_ADDR);
    rej_n <= rej_n + REJECTED;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_plain();
    host.frame(`OP_READ, 32'h00123456, 24, 1, 0, 2, 1);
    check(host.rb[0], pat(25'h0123456));
    check(host.rb[1], pat(25'h0123457));
  endtask
  task automatic t_ext();
    EXTENDED_ADDRESS_REG_BIT <= 1'b1;
    host.frame(`OP_READ, 32'h00FFFFFF, 24, 1, 0, 2, 1);
    check(host.rb[0], pat(25'h1FFFFFF));
    check(host.rb[1], pat(25'h0000000));
    EXTENDED_ADDRESS_REG_BIT <= 1'b0;
  endtask
  task automatic t_wide();
    host.frame(`OP_ENTER_WIDE, 32'h0, 0, 1, 0, 0, 1);
    check({7'h00, WIDE_ADDRESS_FLAG}, 8'h01);
    check(CFG_VIEW & 8'h20, 8'h20);
    host.frame(`OP_FAST_READ, 32'h01000010, 32, 1, 8, 1, 1);
    check(host.rb[0], pat(25'h1000010));
    host.frame(`OP_SIGNATURE, 32'h0, 24, 1, 0, 0, 1);
    check({7'h00, WIDE_ADDRESS_FLAG}, 8'h01);
    host.frame(`OP_EXIT_WIDE, 32'h0, 0, 1, 0, 0, 1);
    check(CFG_VIEW & 8'h20, 8'h00);
    host.frame(`OP_READ, 32'h00000010, 24, 1, 0, 1, 1);
    check(host.rb[0], pat(25'h0000010));
  endtask
  task automatic t_dual();
    for (int s = 0; s < 4; s++) begin
      {DUMMY_COUNT_SEL_HI, DUMMY_COUNT_SEL_LO} <= s[1:0];
      host.frame(`OP_DUAL_IO, 32'h00ABCDE0 + s, 24, 2, s[0] ? 8 : 4, 2, 2);
      check(host.rb[1], pat(25'h0ABCDE1 + s));
      host.frame(`OP_DUAL_OUT, 32'h00000100 + s, 24, 1, 8, 1, 2);
      check(host.rb[0], pat(25'h0000100 + s));
      check(CFG_VIEW & 8'hC0, {s[1:0], 6'h00});
    end
  endtask
  task automatic t_busy();
    int n;
    n = rej_n;
    BUSY <= 1'b1;
    host.frame(`OP_READ, 32'h00000020, 24, 1, 0, 1, 1);
    check((rej_n > n) ? 8'h01 : 8'h00, 8'h01);
    BUSY <= 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    t_plain();
    t_ext();
    t_wide();
    t_dual();
    t_busy();
    t_plain();
    close_out();
  end
  // watchdog
  initial begin
    #100us;
    mismatches++;
    close_out();
  end
endmodule // serial_flash_read_addr_mode_tb
